// *** hdl/scc_top.sv ***
// Interrupt history, code clamp and register slave for sensor readout
`timescale 1ns/10ps
`default_nettype none
module scc_top
(
	// Clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// Interrupt entry strobes, same clock
	input wire logic lvd_entry_in,
	input wire logic pwu_entry_in,
	input wire logic tof_entry_in,
	input wire logic adc_entry_in,
	input wire logic lfr_entry_in,
	input wire logic rti_entry_in,
	input wire logic keypad_entry_in,
	input wire logic receiver_error_flag_in,
	input wire logic routine_busy_in,
	// Power modes
	input wire logic deep_stop_one_in,
	input wire logic deep_stop_four_in,
	// Measurement in
	input wire logic meas_valid_in,
	input wire logic [11:0] raw_code_in,
	input wire logic signed [13:0] comp_code_in,
	input wire scc_pkg::scc_chan_t chan_in,
	// Measurement out
	output logic code_valid_out,
	output logic [8:0] code_out,
	output logic [7:0] meas_status_out,
	// System outputs
	output logic lfr_user_vector_out,
	output logic wdog_enable_out,
	output logic irq_out,
	// AXI4-Lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Bus state
	logic aw_held_q, aw_held_d;
	logic w_held_q, w_held_d;
	logic [9:0] wr_idx_q, wr_idx_d;
	logic [31:0] wr_data_q, wr_data_d;
	logic [3:0] wr_strb_q, wr_strb_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	// Register state
	logic [7:0] scratch_q, scratch_d;
	logic [11:0] lim_min_q, lim_min_d;
	logic [11:0] lim_low_q, lim_low_d;
	logic [11:0] lim_high_q, lim_high_d;
	logic [11:0] lim_max_q, lim_max_d;
	logic [2:0] irq_stat_q, irq_stat_d;
	logic [2:0] irq_en_q, irq_en_d;
	logic irq_q, irq_d;
	// Event and measurement state
	logic [8:0] code_q, code_d;
	logic code_valid_q, code_valid_d;
	logic [7:0] mstat_q, mstat_d;
	logic vector_q, vector_d;
	logic wdog_q, wdog_d;
	// Combinational helpers
	logic do_write;
	logic hist_wr;
	logic [7:0] hist_set;
	logic [7:0] hist_val;
	logic [8:0] clamp_code;
	logic clamp_hit;
	logic range_err;
	logic [15:0] lane_mask;
	logic [2:0] irq_evt;
	logic [2:0] irq_clr;
	logic [7:0] err_bit;

	// History triggers, decoded per source
	always_comb
	begin
		hist_set = 8'h00;
		hist_set[scc_pkg::HB_LVD] = lvd_entry_in;
		hist_set[scc_pkg::HB_PWU] = pwu_entry_in;
		hist_set[scc_pkg::HB_TOF] = tof_entry_in;
		hist_set[scc_pkg::HB_ADC] = adc_entry_in;
		hist_set[scc_pkg::HB_RTI] = rti_entry_in;
		hist_set[scc_pkg::HB_KEYPAD] = keypad_entry_in;
		hist_set[scc_pkg::HB_LFR_ERR] =
			lfr_entry_in & receiver_error_flag_in;
		hist_set[scc_pkg::HB_LFR_OK] =
			lfr_entry_in & ~receiver_error_flag_in;
	end

	scc_history u_history
	(
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.set_in(hist_set),
		.wr_in(hist_wr),
		.wdata_in(wr_data_q[7:0]),
		.hist_out(hist_val)
	);

	scc_clamp u_clamp
	(
		.raw_in(raw_code_in),
		.comp_in(comp_code_in),
		.chan_in(chan_in),
		.lim_min_in(lim_min_q),
		.lim_low_in(lim_low_q),
		.lim_high_in(lim_high_q),
		.lim_max_in(lim_max_q),
		.code_out(clamp_code),
		.clamp_out(clamp_hit),
		.range_err_out(range_err)
	);

	// Write commits once address and data are both held
	always_comb
	begin
		do_write = aw_held_q & w_held_q & ~bvalid_q;
		lane_mask = {{8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
		hist_wr = do_write & wr_strb_q[0] &
			(wr_idx_q == scc_pkg::IDX_HISTORY);
	end

	// Channel error bit for a railed input
	always_comb
	begin
		err_bit = 8'h00;
		case (chan_in)
			scc_pkg::SCC_CH_VOLT: err_bit[scc_pkg::ST_VOLT_ERR] = 1'b1;
			scc_pkg::SCC_CH_TEMP: err_bit[scc_pkg::ST_TEMP_ERR] = 1'b1;
			scc_pkg::SCC_CH_PRESS: err_bit[scc_pkg::ST_PRESS_ERR] = 1'b1;
			scc_pkg::SCC_CH_ACCEL: err_bit[scc_pkg::ST_ACCEL_ERR] = 1'b1;
			default: err_bit = 8'h00;
		endcase
	end

	// Next state of bus channels and software registers
	always_comb
	begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		wr_idx_d = wr_idx_q;
		wr_data_d = wr_data_q;
		wr_strb_d = wr_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		scratch_d = scratch_q;
		lim_min_d = lim_min_q;
		lim_low_d = lim_low_q;
		lim_high_d = lim_high_q;
		lim_max_d = lim_max_q;
		irq_en_d = irq_en_q;
		irq_clr = 3'h0;
		// Capture address and data independently, in either order
		if (s_axi_awvalid & awready_q)
		begin
			aw_held_d = 1'b1;
			wr_idx_d = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid & wready_q)
		begin
			w_held_d = 1'b1;
			wr_data_d = s_axi_wdata;
			wr_strb_d = s_axi_wstrb;
		end
		if (s_axi_bvalid & s_axi_bready)
			bvalid_d = 1'b0;
		if (do_write)
		begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = scc_pkg::RESP_OKAY;
			case (wr_idx_q)
				scc_pkg::IDX_SCRATCH:
					if (wr_strb_q[0])
						scratch_d = wr_data_q[7:0];
				scc_pkg::IDX_HISTORY: ;
				scc_pkg::IDX_LIM_MIN:
					lim_min_d = (lim_min_q & ~lane_mask[11:0]) |
						(wr_data_q[11:0] & lane_mask[11:0]);
				scc_pkg::IDX_LIM_LOW:
					lim_low_d = (lim_low_q & ~lane_mask[11:0]) |
						(wr_data_q[11:0] & lane_mask[11:0]);
				scc_pkg::IDX_LIM_HIGH:
					lim_high_d = (lim_high_q & ~lane_mask[11:0]) |
						(wr_data_q[11:0] & lane_mask[11:0]);
				scc_pkg::IDX_LIM_MAX:
					lim_max_d = (lim_max_q & ~lane_mask[11:0]) |
						(wr_data_q[11:0] & lane_mask[11:0]);
				scc_pkg::IDX_IRQ_EN:
					if (wr_strb_q[0])
						irq_en_d = wr_data_q[2:0];
				scc_pkg::IDX_IRQ_CLR:
					if (wr_strb_q[0])
						irq_clr = wr_data_q[2:0];
				scc_pkg::IDX_RESULT, scc_pkg::IDX_IRQ_STAT,
				scc_pkg::IDX_WDOG: ;
				default: bresp_d = scc_pkg::RESP_SLVERR;
			endcase
		end
		// Ready again only once nothing of this write is left in flight
		awready_d = ~aw_held_d & ~bvalid_d;
		wready_d = ~w_held_d & ~bvalid_d;
		// Read answers one cycle after the address is taken
		if (s_axi_rvalid & s_axi_rready)
		begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid & arready_q)
		begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = scc_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			case (s_axi_araddr[11:2])
				scc_pkg::IDX_SCRATCH: rdata_d[7:0] = scratch_q;
				scc_pkg::IDX_HISTORY: rdata_d[7:0] = hist_val;
				scc_pkg::IDX_LIM_MIN: rdata_d[11:0] = lim_min_q;
				scc_pkg::IDX_LIM_LOW: rdata_d[11:0] = lim_low_q;
				scc_pkg::IDX_LIM_HIGH: rdata_d[11:0] = lim_high_q;
				scc_pkg::IDX_LIM_MAX: rdata_d[11:0] = lim_max_q;
				scc_pkg::IDX_RESULT:
					rdata_d[16:0] = {mstat_q, code_q};
				scc_pkg::IDX_IRQ_STAT: rdata_d[2:0] = irq_stat_q;
				scc_pkg::IDX_IRQ_EN: rdata_d[2:0] = irq_en_q;
				scc_pkg::IDX_IRQ_CLR: ;
				scc_pkg::IDX_WDOG: rdata_d[0] = wdog_q;
				default: rresp_d = scc_pkg::RESP_SLVERR;
			endcase
		end
	end

	// Measurement result, events and interrupt line
	always_comb
	begin
		code_valid_d = meas_valid_in;
		code_d = code_q;
		mstat_d = mstat_q;
		if (meas_valid_in)
		begin
			code_d = clamp_code;
			// Status covers the latest measurement only
			mstat_d = range_err ? err_bit : 8'h00;
			mstat_d[scc_pkg::ST_CLAMP] = clamp_hit;
		end
		irq_evt = 3'h0;
		irq_evt[scc_pkg::IRQ_HIST] = |hist_set;
		irq_evt[scc_pkg::IRQ_CLAMP] = meas_valid_in & clamp_hit;
		irq_evt[scc_pkg::IRQ_RANGE] = meas_valid_in & range_err;
		// A new event outranks a clear in the same cycle
		irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
		irq_d = |(irq_stat_q & irq_en_q);
		// Vector suppressed while a built-in routine runs
		vector_d = lfr_entry_in & ~routine_busy_in;
		wdog_d = ~(deep_stop_one_in | deep_stop_four_in);
	end

	// Register everything; clock enable freezes all state
	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			wr_idx_q <= 10'h000;
			wr_data_q <= 32'h0000_0000;
			wr_strb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= scc_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= scc_pkg::RESP_OKAY;
			scratch_q <= scc_pkg::SCRATCH_RST;
			lim_min_q <= scc_pkg::LIM_MIN_RST;
			lim_low_q <= scc_pkg::LIM_LOW_RST;
			lim_high_q <= scc_pkg::LIM_HIGH_RST;
			lim_max_q <= scc_pkg::LIM_MAX_RST;
			irq_stat_q <= 3'h0;
			irq_en_q <= scc_pkg::IRQ_EN_RST;
			irq_q <= 1'b0;
			code_q <= scc_pkg::CODE_RAIL_LO;
			code_valid_q <= 1'b0;
			mstat_q <= 8'h00;
			vector_q <= 1'b0;
			wdog_q <= 1'b1;
		end
		else if (ce_in)
		begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			wr_idx_q <= wr_idx_d;
			wr_data_q <= wr_data_d;
			wr_strb_q <= wr_strb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= (rvalid_q | (s_axi_arvalid & arready_q)) ?
				arready_d : 1'b1;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			scratch_q <= scratch_d;
			lim_min_q <= lim_min_d;
			lim_low_q <= lim_low_d;
			lim_high_q <= lim_high_d;
			lim_max_q <= lim_max_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
			irq_q <= irq_d;
			code_q <= code_d;
			code_valid_q <= code_valid_d;
			mstat_q <= mstat_d;
			vector_q <= vector_d;
			wdog_q <= wdog_d;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign code_out = code_q;
	assign code_valid_out = code_valid_q;
	assign meas_status_out = mstat_q;
	assign lfr_user_vector_out = vector_q;
	assign wdog_enable_out = wdog_q;
	assign irq_out = irq_q;
endmodule // scc_top
`default_nettype wire

// *** hdl/scc_pkg.sv ***
// Constants, register map and encodings for the sensor status and code clamp
package scc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_SCRATCH = 10'h08E;
	localparam logic [9:0] IDX_HISTORY = 10'h08F;
	localparam logic [9:0] IDX_LIM_MIN = 10'h090;
	localparam logic [9:0] IDX_LIM_LOW = 10'h091;
	localparam logic [9:0] IDX_LIM_HIGH = 10'h092;
	localparam logic [9:0] IDX_LIM_MAX = 10'h093;
	localparam logic [9:0] IDX_RESULT = 10'h094;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h095;
	localparam logic [9:0] IDX_IRQ_EN = 10'h096;
	localparam logic [9:0] IDX_IRQ_CLR = 10'h097;
	localparam logic [9:0] IDX_WDOG = 10'h098;

	// Reset values
	localparam logic [7:0] SCRATCH_RST = 8'h00;
	localparam logic [7:0] HISTORY_RST = 8'h00;
	localparam logic [11:0] LIM_MIN_RST = 12'h020;
	localparam logic [11:0] LIM_LOW_RST = 12'h040;
	localparam logic [11:0] LIM_HIGH_RST = 12'h3C0;
	localparam logic [11:0] LIM_MAX_RST = 12'h3E0;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;

	// History byte bit positions
	localparam int HB_KEYPAD = 0;
	localparam int HB_RTI = 1;
	localparam int HB_LFR_OK = 2;
	localparam int HB_ADC = 3;
	localparam int HB_LFR_ERR = 4;
	localparam int HB_TOF = 5;
	localparam int HB_PWU = 6;
	localparam int HB_LVD = 7;

	// Measurement status byte bit positions
	localparam int ST_CLAMP = 0;
	localparam int ST_PRESS_ERR = 2;
	localparam int ST_ACCEL_ERR = 3;
	localparam int ST_VOLT_ERR = 5;
	localparam int ST_TEMP_ERR = 6;

	// Interrupt status bit positions
	localparam int IRQ_HIST = 0;
	localparam int IRQ_CLAMP = 1;
	localparam int IRQ_RANGE = 2;

	// Raw code spans and output code points
	localparam logic [11:0] RAW_TOP_10 = 12'h3FF;
	localparam logic [11:0] RAW_TOP_12 = 12'hFFF;
	localparam logic [8:0] CODE_RAIL_LO = 9'h000;
	localparam logic [8:0] CODE_RAIL_HI = 9'h1FF;
	localparam logic [8:0] CODE_MIN = 9'h001;
	localparam logic [8:0] CODE_MAX = 9'h1FE;
	localparam logic signed [13:0] COMP_MIN = 14'sh0001;
	localparam logic signed [13:0] COMP_MAX = 14'sh01FE;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Measurement channel
	typedef enum logic [1:0] {
		SCC_CH_VOLT = 2'b00,
		SCC_CH_TEMP = 2'b01,
		SCC_CH_PRESS = 2'b10,
		SCC_CH_ACCEL = 2'b11
	} scc_chan_t;

endpackage

// *** hdl/scc_history.sv ***
// Sticky interrupt-history byte, one flop per bit
`timescale 1ns/10ps
`default_nettype none
module scc_history
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// Trigger and processor write
	input wire logic [7:0] set_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	// Held value
	output logic [7:0] hist_out
);
	logic [7:0] hist_q;
	logic [7:0] hist_d;

	// Each bit holds until written; a trigger beats a same-cycle clear
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_bit
			always_comb
			begin
				hist_d[gi] = (wr_in ? wdata_in[gi] : hist_q[gi]) | set_in[gi];
			end
			// Nothing but a write or a trigger moves the bit
			always_ff @(posedge clk_sys_in or negedge nrst_in)
			begin
				if (!nrst_in)
					hist_q[gi] <= scc_pkg::HISTORY_RST[gi];
				else if (ce_in)
					hist_q[gi] <= hist_d[gi];
			end
		end
	endgenerate

	assign hist_out = hist_q;
endmodule // scc_history
`default_nettype wire

// *** hdl/scc_clamp.sv ***
// Combinational range check and clamp of a compensated result
`timescale 1ns/10ps
`default_nettype none
module scc_clamp
(
	// Measurement
	input wire logic [11:0] raw_in,
	input wire logic signed [13:0] comp_in,
	input wire scc_pkg::scc_chan_t chan_in,
	// Input limits
	input wire logic [11:0] lim_min_in,
	input wire logic [11:0] lim_low_in,
	input wire logic [11:0] lim_high_in,
	input wire logic [11:0] lim_max_in,
	// Result
	output logic [8:0] code_out,
	output logic clamp_out,
	output logic range_err_out
);
	logic [11:0] raw_top;
	logic rail_lo;
	logic rail_hi;
	logic under;
	logic over;

	// Rails win over underflow and overflow; unclipped results pass
	always_comb
	begin
		raw_top = (chan_in == scc_pkg::SCC_CH_TEMP) ?
			scc_pkg::RAW_TOP_12 : scc_pkg::RAW_TOP_10;
		rail_lo = raw_in < lim_min_in;
		rail_hi = (raw_in > lim_max_in) || (raw_in > raw_top);
		under = (raw_in < lim_low_in) || (comp_in < scc_pkg::COMP_MIN);
		over = (raw_in > lim_high_in) || (comp_in > scc_pkg::COMP_MAX);
		range_err_out = rail_lo || rail_hi;
		clamp_out = 1'b0;
		if (rail_lo)
			code_out = scc_pkg::CODE_RAIL_LO;
		else if (rail_hi)
			code_out = scc_pkg::CODE_RAIL_HI;
		else if (under)
		begin
			code_out = scc_pkg::CODE_MIN;
			clamp_out = 1'b1;
		end
		else if (over)
		begin
			code_out = scc_pkg::CODE_MAX;
			clamp_out = 1'b1;
		end
		else
			code_out = comp_in[8:0];
	end
endmodule // scc_clamp
`default_nettype wire

// *** test/scc_fw_model.sv ***
// Firmware-side model: enters a deep stop mode and wakes by periodic timer
`timescale 1ns/10ps
`default_nettype none
module scc_fw_model
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Request from the bench
	input wire logic go_in,
	input wire logic which_in,
	// Stop levels and backup wake strobe
	output logic stop_one_out,
	output logic stop_four_out,
	output logic wake_out
);
	logic [3:0] cnt_q;
	// Watchdog is off in stop, so a periodic wakeup must end the stay
	always @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cnt_q <= 4'h0;
			stop_one_out <= 1'b0;
			stop_four_out <= 1'b0;
			wake_out <= 1'b0;
		end
		else
		begin
			wake_out <= 1'b0;
			if (go_in && cnt_q == 4'h0)
			begin
				cnt_q <= 4'h8;
				stop_one_out <= !which_in;
				stop_four_out <= which_in;
			end
			else if (cnt_q == 4'h1)
			begin
				cnt_q <= 4'h0;
				stop_one_out <= 1'b0;
				stop_four_out <= 1'b0;
				wake_out <= 1'b1;
			end
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule // scc_fw_model
`default_nettype wire

// *** test/scc_top_asserts.sv ***
// Concurrent checks on the sensor status and code clamp ports
`timescale 1ns/10ps
`default_nettype none
module scc_top_asserts
(
	// Clock and control
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic lfr_entry_in,
	input wire logic routine_busy_in,
	input wire logic deep_stop_one_in,
	input wire logic deep_stop_four_in,
	input wire logic meas_valid_in,
	// Outputs
	input wire logic code_valid_out,
	input wire logic [8:0] code_out,
	input wire logic [7:0] meas_status_out,
	input wire logic lfr_user_vector_out,
	input wire logic wdog_enable_out,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	// Range error bits of the status byte
	localparam logic [7:0] ERR_MASK = 8'h6C;
	sequence s_lfr;
		ce_in && lfr_entry_in;
	endsequence
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_vec;
		s_lfr ##0 !routine_busy_in |=> lfr_user_vector_out;
	endproperty
	a_vec: assert property (p_vec) else $error("vector missing");
	property p_novec;
		s_lfr ##0 routine_busy_in |=> !lfr_user_vector_out;
	endproperty
	a_novec: assert property (p_novec) else $error("vector taken");
	property p_wd_off;
		ce_in && (deep_stop_one_in || deep_stop_four_in) |=> !wdog_enable_out;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("watchdog on");
	property p_wd_on;
		ce_in && !deep_stop_one_in && !deep_stop_four_in |=> wdog_enable_out;
	endproperty
	a_wd_on: assert property (p_wd_on) else $error("watchdog off");
	property p_cv;
		ce_in && meas_valid_in |=> code_valid_out;
	endproperty
	a_cv: assert property (p_cv) else $error("no code valid");
	property p_clip;
		code_valid_out && meas_status_out[0] |-> code_out == 9'h001
			|| code_out == 9'h1FE;
	endproperty
	a_clip: assert property (p_clip) else $error("clip code wrong");
	property p_rsv;
		code_valid_out && (meas_status_out & ERR_MASK) == 8'h00
			|-> code_out inside {[9'h001:9'h1FE]};
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code");
	property p_rail;
		code_valid_out && (code_out == 9'h000 || code_out == 9'h1FF)
			|-> (meas_status_out & ERR_MASK) != 8'h00;
	endproperty
	a_rail: assert property (p_rail) else $error("rail without error");
	property p_wr;
		s_wtake |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("no write response");
	property p_bst;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bst: assert property (p_bst) else $error("bresp dropped");
	property p_rst;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rst: assert property (p_rst) else $error("rdata dropped");
endmodule // scc_top_asserts
bind scc_top scc_top_asserts u_chk (.clk_sys_in, .nrst_in, .ce_in,
	.lfr_entry_in, .routine_busy_in, .deep_stop_one_in, .deep_stop_four_in,
	.meas_valid_in, .code_valid_out, .code_out, .meas_status_out,
	.lfr_user_vector_out, .wdog_enable_out, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** test/scc_top_tb.sv ***
// Self-checking bench for the sensor status and code clamp
`timescale 1ns/10ps
`default_nettype none
module scc_top_tb;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic ce_in = 1'b1;
	logic [6:0] ent = 7'h00;
	logic receiver_error_flag_in = 1'b0;
	logic routine_busy_in = 1'b0;
	logic meas_valid_in = 1'b0;
	logic [11:0] raw_code_in = 12'h000;
	logic signed [13:0] comp_code_in = 14'sh0000;
	scc_pkg::scc_chan_t chan_in = scc_pkg::SCC_CH_VOLT;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0, which = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, seed = 32'hB5C24DE7;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic m_one, m_four, m_wake, code_valid_out, lfr_user_vector_out;
	logic wdog_enable_out, irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [8:0] code_out;
	logic [7:0] meas_status_out;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic signed [13:0] cc;
	int fails = 0, checks = 0;
	int src[8] = '{0, 1, 2, 4, 3, 4, 5, 6};
	logic [11:0] raws[10] = '{12'h01F, 12'h020, 12'h03F, 12'h040, 12'h3C0,
		12'h3C1, 12'h3E0, 12'h3E1, 12'h400, 12'hFFF};
	scc_top uut (.clk_sys_in, .nrst_in, .ce_in, .lvd_entry_in(ent[0]),
		.pwu_entry_in(ent[1] | m_wake), .tof_entry_in(ent[2]),
		.adc_entry_in(ent[3]), .lfr_entry_in(ent[4]), .rti_entry_in(ent[5]),
		.keypad_entry_in(ent[6]), .receiver_error_flag_in, .routine_busy_in,
		.deep_stop_one_in(m_one), .deep_stop_four_in(m_four), .meas_valid_in,
		.raw_code_in, .comp_code_in, .chan_in, .code_valid_out, .code_out,
		.meas_status_out, .lfr_user_vector_out, .wdog_enable_out, .irq_out,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	scc_fw_model u_fw (.clk_sys_in, .nrst_in, .go_in(go), .which_in(which),
		.stop_one_out(m_one), .stop_four_out(m_four), .wake_out(m_wake));
	// 200 MHz clock
	always #2.5 clk_sys_in = ~clk_sys_in;
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Expected {status, code}; rails first, then clips, then pass-through
	function automatic logic [16:0] exp_meas(logic [11:0] r,
		logic signed [13:0] c, logic [1:0] ch);
		logic [7:0] e;
		logic [11:0] top;
		e = 8'h01 << ((ch == 2'b00) ? 5 : (ch == 2'b01) ? 6 : (ch == 2'b10) ? 2 : 3);
		top = (ch == 2'b01) ? 12'hFFF : 12'h3FF;
		if (r < scc_pkg::LIM_MIN_RST) return {e, 9'h000};
		if (r > scc_pkg::LIM_MAX_RST || r > top) return {e, 9'h1FF};
		if (r < scc_pkg::LIM_LOW_RST || c < 14'sh0001) return {8'h01, 9'h001};
		if (r > scc_pkg::LIM_HIGH_RST || c > 14'sh01FE) return {8'h01, 9'h1FE};
		return {8'h00, c[8:0]};
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Bus write: address and data together, each released when taken
	task automatic axw(input logic [9:0] i, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk_sys_in);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge clk_sys_in);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_awvalid || s_axi_wvalid);
		// Sometimes late, so the response must stand while it waits
		seed = xs(seed);
		if (seed[0]) @(posedge clk_sys_in);
		s_axi_bready <= 1'b1;
		do @(posedge clk_sys_in); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		cmp({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic axr(input logic [9:0] i, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk_sys_in);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		do @(posedge clk_sys_in); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		// Sometimes late, so the read data must stand while it waits
		seed = xs(seed);
		if (seed[0]) @(posedge clk_sys_in);
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys_in); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		cmp(s_axi_rdata, ed);
		cmp({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	// One-cycle interrupt entry strobe
	task automatic ev(input int s, input logic e, input logic b);
		@(posedge clk_sys_in);
		ent[s] <= 1'b1;
		receiver_error_flag_in <= e;
		routine_busy_in <= b;
		@(posedge clk_sys_in);
		ent <= 7'h00;
		routine_busy_in <= 1'b0;
	endtask
	task automatic meas(input logic [11:0] r, input logic signed [13:0] c,
		input logic [1:0] ch);
		@(posedge clk_sys_in);
		raw_code_in <= r;
		comp_code_in <= c;
		chan_in <= scc_pkg::scc_chan_t'(ch);
		meas_valid_in <= 1'b1;
		@(posedge clk_sys_in);
		meas_valid_in <= 1'b0;
		#1;
		cmp({31'h0, code_valid_out}, 32'h1);
		cmp({15'h0, meas_status_out, code_out}, {15'h0, exp_meas(r, c, ch)});
	endtask
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		axr(scc_pkg::IDX_SCRATCH, 32'h0, scc_pkg::RESP_OKAY);
		axr(scc_pkg::IDX_HISTORY, 32'h0, scc_pkg::RESP_OKAY);
		axr(scc_pkg::IDX_LIM_MAX, 32'h3E0, scc_pkg::RESP_OKAY);
		axr(10'h000, 32'h0, scc_pkg::RESP_SLVERR);
		axw(10'h3FF, 32'hFF, scc_pkg::RESP_SLVERR);
		axw(scc_pkg::IDX_RESULT, 32'h1FF, scc_pkg::RESP_OKAY);
		// Each source alone, read twice to see it stick, then cleared
		for (int k = 0; k < 8; k++)
		begin
			ev(src[k], k == 3, k == 5);
			axr(scc_pkg::IDX_HISTORY, 32'h1 << (7 - k), scc_pkg::RESP_OKAY);
			axr(scc_pkg::IDX_HISTORY, 32'h1 << (7 - k), scc_pkg::RESP_OKAY);
			axw(scc_pkg::IDX_HISTORY, 32'h0, scc_pkg::RESP_OKAY);
		end
		axr(scc_pkg::IDX_HISTORY, 32'h0, scc_pkg::RESP_OKAY);
		// Interrupt raised, masked, unmasked and cleared
		axw(scc_pkg::IDX_IRQ_EN, 32'h1, scc_pkg::RESP_OKAY);
		ev(5, 1'b0, 1'b0);
		repeat (3) @(posedge clk_sys_in);
		cmp({31'h0, irq_out}, 32'h1);
		axw(scc_pkg::IDX_IRQ_EN, 32'h0, scc_pkg::RESP_OKAY);
		repeat (3) @(posedge clk_sys_in);
		cmp({31'h0, irq_out}, 32'h0);
		axw(scc_pkg::IDX_IRQ_EN, 32'h1, scc_pkg::RESP_OKAY);
		repeat (3) @(posedge clk_sys_in);
		cmp({31'h0, irq_out}, 32'h1);
		axw(scc_pkg::IDX_IRQ_CLR, 32'h1, scc_pkg::RESP_OKAY);
		repeat (3) @(posedge clk_sys_in);
		cmp({31'h0, irq_out}, 32'h0);
		axw(scc_pkg::IDX_HISTORY, 32'h0, scc_pkg::RESP_OKAY);
		// Both stop modes, left by the periodic wakeup
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clk_sys_in);
			which <= s[0];
			go <= 1'b1;
			@(posedge clk_sys_in);
			go <= 1'b0;
			repeat (3) @(posedge clk_sys_in);
			cmp({31'h0, wdog_enable_out}, 32'h0);
			repeat (12) @(posedge clk_sys_in);
			cmp({31'h0, wdog_enable_out}, 32'h1);
			axr(scc_pkg::IDX_HISTORY, 32'h40, scc_pkg::RESP_OKAY);
			axw(scc_pkg::IDX_HISTORY, 32'h0, scc_pkg::RESP_OKAY);
		end
		// Limit boundaries on every channel, then compensation edges
		for (int ch = 0; ch < 4; ch++)
			foreach (raws[j]) meas(raws[j], 14'sd200, ch[1:0]);
		foreach (raws[j]) meas(12'h100, 14'(j * 57) - 14'sd2, 2'b10);
		for (int n = 0; n < 300; n++)
		begin
			seed = xs(seed);
			cc = 14'(seed[21:12]) - 14'sd200;
			meas(seed[31] ? seed[11:0] : {2'b00, seed[9:0]}, cc, seed[25:24]);
		end
		// A trigger while the clock enable is low must leave no mark
		@(posedge clk_sys_in);
		ce_in <= 1'b0;
		ev(0, 1'b0, 1'b0);
		ce_in <= 1'b1;
		axr(scc_pkg::IDX_HISTORY, 32'h0, scc_pkg::RESP_OKAY);
		meas(12'h100, 14'sd600, 2'b10);
		axr(scc_pkg::IDX_RESULT, 32'h3FE, scc_pkg::RESP_OKAY);
		report_and_stop;
	end
	// Hang guard, well past the expected run length
	initial
	begin
		#200000;
		fails++;
		report_and_stop;
	end
endmodule // scc_top_tb
`default_nettype wire
